// file: program_sequencer_stack.sv
/*
 program sequencer: phase divider, fetch/execute pipeline,
 banked program counter, circular return stack, 8-bit alu,
 axi4-lite register slave.
 assumes program memory returns the word for prog_addr within
 four clocks, and interrupt logic holds int_req until int_ack.
*/
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module program_sequencer_stack
    import seq_pkg::*;
(
    input wire logic clk_sys, // 25 mhz system clock
    input wire logic rst, // async reset, active high
    input wire axi_req_t axi_req, // axi4-lite master side
    output axi_rsp_t axi_rsp, // axi4-lite slave answers
    output logic [14:0] prog_addr, // program memory address
    output logic prog_rd, // fetch strobe in phase one
    input wire logic [15:0] prog_data, // fetched instruction word
    input wire logic int_req, // pending enabled interrupt
    input wire logic [14:0] int_vector, // service routine address
    output logic int_ack // acknowledge pulse
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        phase_t phase; // current instruction phase
        logic [14:0] pc; // program counter
        logic [14:0] fa; // address being fetched
        logic [15:0] ir; // instruction in execution
        logic ext; // second half of extended op
        logic boot; // no fetch yet since reset
        logic [7:0] acc; // accumulator
        logic c; // carry flag
        logic z; // zero flag
        logic [1:0] bank; // program_bank_select
        logic [15:0][14:0] stk; // return addresses
        logic [3:0] sp; // next free level
        logic [4:0] cnt; // levels in use
        logic pcl_pend; // bus write to low byte waits
        logic [7:0] pcl_val; // written low byte
        logic prog_rd; // fetch strobe
        logic int_ack; // acknowledge pulse
        logic aw_have; // write address held
        logic w_have; // write data held
        logic [7:0] awaddr; // held write address
        logic [7:0] wdata; // held write data low byte
        logic wlane; // strobe for low byte lane
        axi_rsp_t rsp; // bus answer outputs
    } state_t;

    state_t q; // registered state
    state_t d; // next state

    logic commit; // end of phase four
    logic [2:0] op; // major opcode
    logic [4:0] sub; // misc sub-code
    logic jump_now; // non-sequential pc load
    logic discard; // fetched word is dropped
    logic hold; // extended op first half
    logic push_now; // stack push this commit
    logic pop_now; // stack pop this commit
    logic ack_now; // interrupt taken this commit
    logic [14:0] new_pc; // address of next fetch
    logic [14:0] push_val; // address pushed
    logic [3:0] sp_m1; // top entry index
    logic [14:0] pop_val; // top entry contents
    logic [8:0] alu_out; // carry and result
    logic [7:0] skz_val; // skip test value
    logic [31:0] rd_word; // read data mux
    logic rd_hit; // read address mapped
    logic wr_hit; // write address mapped

    // ------------------------------------------------------------
    // alu
    // ------------------------------------------------------------
    // returns {carry, result}; carry kept where not affected
    function automatic logic [8:0] alu(
        input logic [3:0] f,
        input logic [7:0] a,
        input logic [7:0] b,
        input logic ci
    );
        logic [8:0] r;
        r = {ci, a};
        unique case (f)
            AF_MOV: r = {ci, b};
            AF_ADD: r = {1'b0, a} + {1'b0, b};
            AF_ADC: r = {1'b0, a} + {1'b0, b} + {8'h00, ci};
            AF_SUB: r = {1'b0, a} + {1'b0, ~b} + 9'h001;
            AF_SBC: r = {1'b0, a} + {1'b0, ~b} + {8'h00, ci};
            AF_AND: r = {ci, a & b};
            AF_OR: r = {ci, a | b};
            AF_XOR: r = {ci, a ^ b};
            AF_CPL: r = {ci, ~a};
            AF_RR: r = {ci, a[0], a[7:1]};
            AF_RL: r = {ci, a[6:0], a[7]};
            AF_RRC: r = {a[0], ci, a[7:1]};
            AF_RLC: r = {a[7], a[6:0], ci};
            AF_INC: r = {ci, a + 8'h01};
            AF_DEC: r = {ci, a - 8'h01};
            default: r = {ci, a};
        endcase
        return r;
    endfunction : alu

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    assign commit = (q.phase == PH_T4);
    assign op = q.ir[15:13];
    assign sub = q.ir[12:8];
    assign sp_m1 = q.sp - 4'h1;
    assign pop_val = q.stk[sp_m1];
    assign alu_out = alu(q.ir[11:8], q.acc, q.ir[7:0], q.c);
    assign skz_val = q.ir[8] ? (q.acc - 8'h01) : q.acc;

    // read mux; stack and its pointer have no address
    always_comb begin : read_mux
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (axi_req.araddr)
            RA_PCL: rd_word[7:0] = q.pc[7:0];
            RA_BANK: rd_word[1:0] = q.bank;
            RA_ACC: rd_word[7:0] = q.acc;
            RA_STAT: begin
                rd_word[SB_C] = q.c;
                rd_word[SB_Z] = q.z;
                rd_word[SB_FULL] = (q.cnt == STK_FULL);
                rd_word[SB_PEND] = q.pcl_pend;
            end
            RA_PC: rd_word[14:0] = q.pc;
            default: rd_hit = 1'b0;
        endcase
    end

    // writable addresses
    assign wr_hit = (q.awaddr == RA_PCL) || (q.awaddr == RA_BANK);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin : next_state
        d = q;
        jump_now = 1'b0;
        discard = q.boot;
        hold = 1'b0;
        push_now = 1'b0;
        pop_now = 1'b0;
        ack_now = 1'b0;
        new_pc = q.pc;
        push_val = q.fa;
        d.prog_rd = 1'b0;
        d.int_ack = 1'b0;
        // four phases per instruction cycle
        unique case (q.phase)
            PH_T1: d.phase = PH_T2;
            PH_T2: d.phase = PH_T3;
            PH_T3: d.phase = PH_T4;
            PH_T4: d.phase = PH_T1;
        endcase
        // execute the instruction at the end of phase four
        if (commit) begin
            unique case (op)
                OP_MISC: begin
                    if (sub == MS_RET || sub == MS_INTERRUPT_RETURN_INSTR) begin
                        pop_now = 1'b1;
                        new_pc = pop_val;
                        jump_now = 1'b1;
                    end else if (sub == MS_EXT && !q.ext) begin
                        hold = 1'b1;
                    end
                end
                OP_ALU: begin
                    d.acc = alu_out[7:0];
                    d.c = alu_out[8];
                    d.z = (alu_out[7:0] == 8'h00);
                end
                OP_JMP: begin
                    new_pc = {q.bank, q.ir[12:0]};
                    jump_now = 1'b1;
                end
                OP_CALL: begin
                    new_pc = {q.bank, q.ir[12:0]};
                    jump_now = 1'b1;
                    push_now = 1'b1;
                end
                OP_SKZ: begin
                    if (q.ir[8]) begin
                        d.acc = skz_val;
                        d.z = (skz_val == 8'h00);
                    end
                    if (skz_val == 8'h00) begin
                        discard = 1'b1;
                    end
                end
                OP_PCL: begin
                    new_pc = {q.fa[14:8], q.acc};
                    jump_now = 1'b1;
                end
                OP_BANK: d.bank = q.ir[1:0];
                default: ;
            endcase
            // bus write to the low byte jumps inside the page
            if (q.pcl_pend && !jump_now && !hold) begin
                new_pc = {q.fa[14:8], q.pcl_val};
                jump_now = 1'b1;
                d.pcl_pend = 1'b0;
            end
            // interrupt waits while the stack is full
            if (int_req && !jump_now && !hold && !discard
                && q.cnt != STK_FULL) begin
                ack_now = 1'b1;
                push_now = 1'b1;
                new_pc = int_vector;
                jump_now = 1'b1;
                d.int_ack = 1'b1;
            end
            if (jump_now) begin
                discard = 1'b1;
            end
            // circular stack; full push drops the oldest
            if (push_now) begin
                d.stk[q.sp] = push_val;
                d.sp = q.sp + 4'h1;
                if (q.cnt != STK_FULL) begin
                    d.cnt = q.cnt + 5'h01;
                end
            end else if (pop_now) begin
                d.sp = sp_m1;
                if (q.cnt != 5'h00) begin
                    d.cnt = q.cnt - 5'h01;
                end
            end
            // overlapped fetch of the next word
            if (hold) begin
                d.ext = 1'b1;
            end else begin
                d.ext = 1'b0;
                d.boot = 1'b0;
                d.fa = new_pc;
                d.pc = new_pc + 15'h0001;
                d.prog_rd = 1'b1;
                d.ir = discard ? NOP_WORD : prog_data;
            end
        end

        // axi write address and data, either order
        if (axi_req.awvalid && q.rsp.awready) begin
            d.aw_have = 1'b1;
            d.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && q.rsp.wready) begin
            d.w_have = 1'b1;
            d.wdata = axi_req.wdata[7:0];
            d.wlane = axi_req.wstrb[0];
        end
        // response retires
        if (q.rsp.bvalid && axi_req.bready) begin
            d.rsp.bvalid = 1'b0;
        end
        // perform the write once both halves are held
        if (q.aw_have && q.w_have && !q.rsp.bvalid) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.rsp.bvalid = 1'b1;
            d.rsp.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
            if (q.wlane && q.awaddr == RA_PCL) begin
                d.pcl_pend = 1'b1;
                d.pcl_val = q.wdata;
            end
            if (q.wlane && q.awaddr == RA_BANK) begin
                d.bank = q.wdata[1:0];
            end
        end
        d.rsp.awready = !d.aw_have && !d.rsp.bvalid;
        d.rsp.wready = !d.w_have && !d.rsp.bvalid;

        // axi read
        if (q.rsp.rvalid && axi_req.rready) begin
            d.rsp.rvalid = 1'b0;
            d.rsp.arready = 1'b1;
        end
        if (axi_req.arvalid && q.rsp.arready) begin
            d.rsp.arready = 1'b0;
            d.rsp.rvalid = 1'b1;
            d.rsp.rdata = rd_word;
            d.rsp.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // reset enters phase four so the first edge fetches the vector
    always_ff @(posedge clk_sys or posedge rst) begin : state_reg
        if (rst) begin
            q <= '0;
            q.phase <= PH_T4;
            q.pc <= RESET_VEC;
            q.fa <= RESET_VEC;
            q.boot <= 1'b1;
            q.cnt <= 5'h00;
            q.sp <= 4'h0;
            q.rsp.awready <= 1'b1;
            q.rsp.wready <= 1'b1;
            q.rsp.arready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign axi_rsp = q.rsp;
    assign prog_addr = q.fa;
    assign prog_rd = q.prog_rd;
    assign int_ack = q.int_ack;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    phase_wrap_a: assert property (
        q.phase == PH_T1 |=> q.phase == PH_T2 ##1 q.phase == PH_T3
            ##1 q.phase == PH_T4 ##1 q.phase == PH_T1)
        else $error("phase sequence broken");

    fetch_phase_a: assert property (
        prog_rd |-> q.phase == PH_T1 && q.pc == q.fa + 15'h0001)
        else $error("fetch outside phase one");

    ext_stall_a: assert property (
        commit && hold |=> $stable(q.fa) && !prog_rd && q.ext)
        else $error("extended op did not stall");

    branch_dummy_a: assert property (
        commit && jump_now && !hold |=> q.ir == NOP_WORD)
        else $error("branch kept fetched word");

    pc_step_a: assert property (
        commit && !jump_now && !hold && !q.boot
            |=> q.fa == $past(q.pc))
        else $error("pc did not step by one");

    skip_dummy_a: assert property (
        commit && op == OP_SKZ && skz_val == 8'h00
            |=> q.ir == NOP_WORD)
        else $error("skip kept fetched word");

    pcl_page_a: assert property (
        commit && op == OP_PCL && !ack_now
            |=> q.fa[14:8] == $past(q.fa[14:8])
                && q.fa[7:0] == $past(q.acc))
        else $error("low byte jump left page");

    push_count_a: assert property (
        push_now && q.cnt != STK_FULL
            |=> q.cnt == $past(q.cnt) + 5'h01)
        else $error("push did not grow stack");

    pop_restore_a: assert property (
        commit && pop_now |=> q.fa == $past(pop_val))
        else $error("return address wrong");

    reset_empty_a: assert property (
        @(posedge clk_sys) $fell(rst) |-> q.cnt == 5'h00)
        else $error("stack not empty after reset");

    full_noack_a: assert property (
        int_ack |-> $past(q.cnt) != STK_FULL)
        else $error("acknowledge with full stack");

    call_overflow_a: assert property (
        commit && op == OP_CALL && q.cnt == STK_FULL
            |=> q.cnt == STK_FULL && q.fa == $past(new_pc))
        else $error("call on full stack failed");

    zero_flag_a: assert property (
        commit && op == OP_ALU |=> q.z == (q.acc == 8'h00))
        else $error("zero flag wrong");
endmodule : program_sequencer_stack

// file: seq_pkg.sv
/*
 constants, types and carriers for the program sequencer.
 assumes one 25 mhz system clock and an axi4-lite master.
*/
// ----------------------------------------------------------------
// Overview of operation
// - four phases make one instruction cycle
// - pc steps at phase one, fetch then
// - fetch overlaps execute, extended takes two
// - branches cost one extra cycle
// - pc steps by one unless transferred
// - pc is bank, upper five, low byte
// - only pc low byte is addressable; the whole pc also reads at RA_PC, writes refused
// - jump, call, interrupt, reset load pc
// - taken skip discards fetched, dummy cycle
// - low byte write jumps within page
// - sixteen-entry stack, never readable or writable
// - call or interrupt acknowledge pushes pc
// - return pops stack into pc
// - reset leaves stack empty
// - full stack holds interrupt acknowledge back
// - call on full stack still executes
// - eight-bit alu through the accumulator
// - alu results update status flags
// ----------------------------------------------------------------
package seq_pkg;
    // program counter width, stack depth, reset vector and dummy word
    localparam int PC_W = 15;
    localparam int STK_N = 16;
    localparam logic [4:0] STK_FULL = 5'h10;
    localparam logic [14:0] RESET_VEC = 15'h0000;
    localparam logic [15:0] NOP_WORD = 16'h0000;
    // major opcodes, instruction bits 15:13
    localparam logic [2:0] OP_MISC = 3'h0;
    localparam logic [2:0] OP_ALU = 3'h1;
    localparam logic [2:0] OP_JMP = 3'h2;
    localparam logic [2:0] OP_CALL = 3'h3;
    localparam logic [2:0] OP_SKZ = 3'h4;
    localparam logic [2:0] OP_PCL = 3'h5;
    localparam logic [2:0] OP_BANK = 3'h6;
    // misc sub-codes, bits 12:8
    localparam logic [4:0] MS_RET = 5'h01;
    localparam logic [4:0] MS_INTERRUPT_RETURN_INSTR = 5'h02;
    localparam logic [4:0] MS_EXT = 5'h03;
    // alu functions, bits 11:8
    localparam logic [3:0] AF_MOV = 4'h0;
    localparam logic [3:0] AF_ADD = 4'h1;
    localparam logic [3:0] AF_ADC = 4'h2;
    localparam logic [3:0] AF_SUB = 4'h3;
    localparam logic [3:0] AF_SBC = 4'h4;
    localparam logic [3:0] AF_AND = 4'h5;
    localparam logic [3:0] AF_OR = 4'h6;
    localparam logic [3:0] AF_XOR = 4'h7;
    localparam logic [3:0] AF_CPL = 4'h8;
    localparam logic [3:0] AF_RR = 4'h9;
    localparam logic [3:0] AF_RL = 4'hA;
    localparam logic [3:0] AF_RRC = 4'hB;
    localparam logic [3:0] AF_RLC = 4'hC;
    localparam logic [3:0] AF_INC = 4'hD;
    localparam logic [3:0] AF_DEC = 4'hE;
    // register byte addresses
    localparam logic [7:0] RA_PCL = 8'h00;
    localparam logic [7:0] RA_BANK = 8'h04;
    localparam logic [7:0] RA_ACC = 8'h08;
    localparam logic [7:0] RA_STAT = 8'h0C;
    localparam logic [7:0] RA_PC = 8'h10;
    // status register bit positions
    localparam int SB_C = 0;
    localparam int SB_Z = 1;
    localparam int SB_FULL = 2;
    localparam int SB_PEND = 3;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PH_T1 = 2'b00,
        PH_T2 = 2'b01,
        PH_T3 = 2'b10,
        PH_T4 = 2'b11
    } phase_t;

    // master to slave
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axi_req_t;

    // slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_t;
endpackage : seq_pkg

// file: prog_mem_model.sv
/*
 program memory and interrupt request model for the sequencer.
 assumes the bench loads words into mem before reset is released.
*/
`timescale 1ns/1ps
module prog_mem_model
    import seq_pkg::*;
#(
    parameter logic [14:0] VEC = 15'h0060 // service routine address
) (
    input wire logic clk_sys, // system clock
    input wire logic rst, // async reset, active high
    input wire logic [14:0] prog_addr, // fetch address
    input wire logic prog_rd, // fetch strobe
    output logic [15:0] prog_data, // instruction word
    input wire logic int_raise, // bench asks for an interrupt
    input wire logic int_ack, // acknowledge from the sequencer
    output logic int_req, // pending request level
    output logic [14:0] int_vector // service address
);
    // ----------------------------------------------------------------
    // memory
    // ----------------------------------------------------------------
    logic [15:0] mem [256]; // low 256 words, address wraps

    // fill with the dummy word
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = NOP_WORD;
        end
    end

    // word stays valid for as long as the address holds
    assign prog_data = mem[prog_addr[7:0]];
    assign int_vector = VEC;

    // ----------------------------------------------------------------
    // interrupt request
    // ----------------------------------------------------------------
    // request recorded and held until acknowledged
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            int_req <= 1'b0;
        end else if (int_raise) begin
            int_req <= 1'b1;
        end else if (int_ack) begin
            int_req <= 1'b0;
        end
    end
endmodule : prog_mem_model

// file: tb_top.sv
/*
 self-checking bench for the program sequencer.
 assumes the axi4-lite register map and instruction encoding of the sequencer.
*/
`timescale 1ns/1ps
module tb_top
    import seq_pkg::*;
;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk_sys, rst, int_raise, prog_rd, int_req, int_ack;
    axi_req_t axi_req;
    axi_rsp_t axi_rsp;
    logic [14:0] prog_addr, int_vector;
    logic [15:0] prog_data;
    logic [31:0] d;
    logic [1:0] r;
    int err_total, checked, cyc, last_rd, n;
    bit ack_seen;
    logic [14:0] trace [$]; // every fetch address seen
    logic [14:0] pa [9] = '{15'h0, 15'h1, 15'h2, 15'h3, 15'h4, 15'h20, 15'h21, 15'h22, 15'h40};
    logic [15:0] pw [9] = '{16'h2005, 16'h21FC, 16'h8100, 16'h20EE, 16'h4020,
        16'h6040, 16'h2301, 16'h4022, 16'h0100};
    logic [14:0] ex [13] = '{15'h0, 15'h1, 15'h2, 15'h3, 15'h4, 15'h5, 15'h20, 15'h21,
        15'h40, 15'h41, 15'h21, 15'h22, 15'h23};

    program_sequencer_stack program_sequencer_stack_i (.clk_sys(clk_sys), .rst(rst),
        .axi_req(axi_req), .axi_rsp(axi_rsp), .prog_addr(prog_addr), .prog_rd(prog_rd),
        .prog_data(prog_data), .int_req(int_req), .int_vector(int_vector), .int_ack(int_ack));
    prog_mem_model prog_mem_model_i (.clk_sys(clk_sys), .rst(rst), .prog_addr(prog_addr),
        .prog_rd(prog_rd), .prog_data(prog_data), .int_raise(int_raise), .int_ack(int_ack),
        .int_req(int_req), .int_vector(int_vector));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one axi4-lite write, address and data offered together
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        n = 0;
        rs = 2'h3;
        @(posedge clk_sys);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= v;
        axi_req.wstrb <= 4'hF;
        axi_req.bready <= 1'b1;
        while (n < 100) begin
            @(posedge clk_sys);
            n++;
            if (axi_req.awvalid && axi_rsp.awready === 1'b1) axi_req.awvalid <= 1'b0;
            if (axi_req.wvalid && axi_rsp.wready === 1'b1) axi_req.wvalid <= 1'b0;
            if (axi_rsp.bvalid === 1'b1) begin
                rs = axi_rsp.bresp;
                axi_req.bready <= 1'b0;
                n = 1000;
            end
        end
        chk("write answer", 32'h1, 32'(n == 1000));
    endtask : axi_write

    // one axi4-lite read
    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        n = 0;
        rs = 2'h3;
        @(posedge clk_sys);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        axi_req.rready <= 1'b1;
        while (n < 100) begin
            @(posedge clk_sys);
            n++;
            if (axi_req.arvalid && axi_rsp.arready === 1'b1) axi_req.arvalid <= 1'b0;
            if (axi_rsp.rvalid === 1'b1) begin
                v = axi_rsp.rdata;
                rs = axi_rsp.rresp;
                axi_req.rready <= 1'b0;
                n = 1000;
            end
        end
        chk("read answer", 32'h1, 32'(n == 1000));
    endtask : axi_read

    // one-cycle request to the interrupt model
    task automatic raise_int();
        @(posedge clk_sys);
        int_raise <= 1'b1;
        @(posedge clk_sys);
        int_raise <= 1'b0;
    endtask : raise_int

    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // fetch monitor: trace and spacing of fetch strobes
    always @(posedge clk_sys) begin
        cyc++;
        if (rst) begin
            last_rd = 0;
        end else begin
            if (int_ack === 1'b1) ack_seen = 1'b1;
            if (prog_rd === 1'b1) begin
                if (last_rd != 0) chk("fetch spacing", 32'h4, 32'(cyc - last_rd));
                last_rd = cyc;
                trace.push_back(prog_addr);
            end
        end
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        test_done();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        rst = 1'b1;
        int_raise = 1'b0;
        axi_req = '0;
        err_total = 0;
        checked = 0;
        cyc = 0;
        last_rd = 0;
        #1;
        for (int i = 0; i < 9; i++) prog_mem_model_i.mem[pa[i]] = pw[i];
        prog_mem_model_i.mem[8'h60] = 16'hA000; // service page jump to acc value
        prog_mem_model_i.mem[8'hFF] = 16'h0200; // interrupt return
        prog_mem_model_i.mem[8'h80] = 16'h6080; // call to itself
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        // skip, jump, call and return order
        repeat (80) @(posedge clk_sys);
        for (int i = 0; i < 13; i++) chk("fetch address", 32'(ex[i]), 32'(trace[i]));
        axi_read(8'h08, d, r);
        chk("accumulator", 32'hFF, d);
        axi_read(8'h0C, d, r);
        chk("carry and zero", 32'h0, d & 32'h3);
        $display("test fetch order done");
        // interrupt taken into vector and back
        trace.delete();
        raise_int();
        n = 0;
        while (int_ack !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        chk("vector fetch", 32'h60, 32'(prog_addr));
        repeat (60) @(posedge clk_sys);
        chk("resume loop", 32'h1, 32'(trace[$] == 15'h22 || trace[$] == 15'h23));
        chk("request cleared", 32'h0, 32'(int_req));
        $display("test interrupt done");
        // page jump, then calls until the stack is full
        axi_write(8'h00, 32'h80, r);
        chk("low byte write resp", 32'(RESP_OKAY), 32'(r));
        repeat (300) @(posedge clk_sys);
        chk("calls go on", 32'h1, 32'(trace[$] == 15'h80 || trace[$] == 15'h81));
        axi_read(8'h0C, d, r);
        chk("stack full", 32'h1, (d >> 2) & 32'h1);
        ack_seen = 1'b0;
        raise_int();
        repeat (120) @(posedge clk_sys);
        chk("held acknowledge", 32'h0, 32'(ack_seen));
        chk("request kept", 32'h1, 32'(int_req));
        // page jump onto a return frees one level for the waiting request
        axi_write(8'h00, 32'h40, r);
        repeat (60) @(posedge clk_sys);
        chk("ack after return", 32'h1, 32'(ack_seen));
        $display("test full stack done");
        // second reset in mid-run
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        trace.delete();
        rst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk("reset vector", 32'(RESET_VEC), 32'(trace[0]));
        axi_read(8'h0C, d, r);
        chk("stack empty", 32'h0, (d >> 2) & 32'h1);
        axi_read(8'h04, d, r);
        chk("bank reset", 32'h0, d);
        $display("test reset done");
        // register access kinds
        axi_write(8'h04, 32'h2, r);
        axi_read(8'h04, d, r);
        chk("bank select", 32'h2, d);
        axi_write(8'h10, 32'h7FFF, r);
        chk("pc write refused", 32'(RESP_SLVERR), 32'(r));
        axi_write(8'h08, 32'h1, r);
        chk("acc write refused", 32'(RESP_SLVERR), 32'(r));
        axi_read(8'h40, d, r);
        chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
        chk("unmapped data", 32'h0, d);
        $display("test registers done");
        test_done();
    end
endmodule : tb_top
